// ### rtl/acs_ctrl.sv
// acs_ctrl: input select, range/offset selection and calibration control.
// assumes pins are asynchronous to mclk; register port is a simple
// synchronous write/read strobe pair from the serial port decoder.
//
// Functional notes
// - independent mode: each channel converts own input
// - basic interleave: both channels use in-phase input
// - extended interleave: bit 6 selects quadrature input
// - basic mode: one range pin for both
// - extended mode: per-channel range registers 3h, Bh
// - pin high equals mid, low equals min
// - extended mode: offset registers 2h, Ah
// - dc coupling disables bias, one mode both
// - request pin works in both modes
// - extended: request is pin OR bit 15
// - running output high only during calibration
// - pin low enters extended; high resets registers
// - interleave by pin or bit 7, default independent
`timescale 1ns/1ps
module acs_ctrl
    import acs_pkg::*;
#(
    parameter int RUN_CYC = acs_pkg::CAL_RUN_CYC
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        extended_control_pin,
    input  wire logic        interleave_pin,
    input  wire logic        range_select_pin,
    input  wire logic        coupling_mode_select,
    input  wire logic        cal_request_pin,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    output logic             port_enabled,
    output logic             interleave_active,
    output logic             ch_i_sel_quad,
    output logic             ch_q_sel_quad,
    output logic             ch_q_dual_edge,
    output logic      [15:0] ch_i_range,
    output logic      [15:0] ch_q_range,
    output logic      [15:0] ch_i_offset,
    output logic      [15:0] ch_q_offset,
    output logic             bias_enable,
    output logic             calibration_running
);
    import acs_pkg::*;

    // ========================================
    // pin synchronisers, three stages, change once stages 2 and 3 agree
    localparam int NPIN = 5;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] s1_r;
    logic [NPIN-1:0] s2_r;
    logic [NPIN-1:0] s3_r;
    logic [NPIN-1:0] pin_r;
    assign pin_raw = {cal_request_pin, coupling_mode_select, range_select_pin,
                      interleave_pin, extended_control_pin};

    genvar g;
    generate
        for (g = 0; g < NPIN; g++) begin : g_sync
            // reset to high: extended pin idles in basic mode, request idles high
            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    s1_r[g]  <= 1'b1;
                    s2_r[g]  <= 1'b1;
                    s3_r[g]  <= 1'b1;
                    pin_r[g] <= 1'b1;
                end else begin
                    s1_r[g] <= pin_raw[g];
                    s2_r[g] <= s1_r[g];
                    s3_r[g] <= s2_r[g];
                    if (s2_r[g] == s3_r[g]) begin
                        pin_r[g] <= s3_r[g];
                    end
                end
            end
        end
    endgenerate

    logic ext_mode;
    logic dc_coupled;
    assign ext_mode   = ~pin_r[0];
    assign dc_coupled = pin_r[3];

    // ========================================
    // register file; cleared whenever extended control is off
    logic [15:0] cfg_r;
    logic [15:0] i_off_r;
    logic [15:0] i_rng_r;
    logic [15:0] q_off_r;
    logic [15:0] q_rng_r;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cfg_r   <= CFG_RESET;
            i_off_r <= OFFSET_RESET;
            i_rng_r <= RANGE_RESET;
            q_off_r <= OFFSET_RESET;
            q_rng_r <= RANGE_RESET;
        end else if (!ext_mode) begin
            // port disabled, registers back to defaults
            cfg_r   <= CFG_RESET;
            i_off_r <= OFFSET_RESET;
            i_rng_r <= RANGE_RESET;
            q_off_r <= OFFSET_RESET;
            q_rng_r <= RANGE_RESET;
        end else if (reg_wr) begin
            case (reg_addr)
                ADDR_CONFIG:   cfg_r   <= reg_wdata;
                ADDR_I_OFFSET: i_off_r <= reg_wdata;
                ADDR_I_RANGE:  i_rng_r <= reg_wdata;
                ADDR_Q_OFFSET: q_off_r <= reg_wdata;
                ADDR_Q_RANGE:  q_rng_r <= reg_wdata;
                default:       cfg_r   <= cfg_r;
            endcase
        end
    end

    // read data is registered; unmapped or disabled port reads zero
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd && ext_mode) begin
            case (reg_addr)
                ADDR_CONFIG:   reg_rdata <= cfg_r;
                ADDR_I_OFFSET: reg_rdata <= i_off_r;
                ADDR_I_RANGE:  reg_rdata <= i_rng_r;
                ADDR_Q_OFFSET: reg_rdata <= q_off_r;
                ADDR_Q_RANGE:  reg_rdata <= q_rng_r;
                default:       reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // ========================================
    // input selection, range, offset and bias
    logic des_nxt;
    logic qsel_nxt;
    always_comb begin
        des_nxt  = ext_mode ? cfg_r[CFG_DES_BIT] : pin_r[1];
        qsel_nxt = ext_mode & cfg_r[CFG_QSEL_BIT];
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            interleave_active <= 1'b0;
            ch_i_sel_quad     <= 1'b0;
            ch_q_sel_quad     <= 1'b1;
            ch_q_dual_edge    <= 1'b0;
            ch_i_range        <= RANGE_MID;
            ch_q_range        <= RANGE_MID;
            ch_i_offset       <= OFFSET_RESET;
            ch_q_offset       <= OFFSET_RESET;
            bias_enable       <= 1'b1;
            port_enabled      <= 1'b0;
        end else begin
            port_enabled      <= ext_mode;
            interleave_active <= des_nxt;
            // independent: own inputs, rising edge only
            ch_i_sel_quad     <= des_nxt & qsel_nxt;
            ch_q_sel_quad     <= des_nxt ? qsel_nxt : 1'b1;
            ch_q_dual_edge    <= des_nxt;
            if (ext_mode) begin
                ch_i_range  <= i_rng_r;
                ch_q_range  <= q_rng_r;
                ch_i_offset <= i_off_r;
                ch_q_offset <= q_off_r;
            end else begin
                // one pin, same range both channels
                ch_i_range  <= pin_r[2] ? RANGE_MID : RANGE_MIN;
                ch_q_range  <= pin_r[2] ? RANGE_MID : RANGE_MIN;
                ch_i_offset <= OFFSET_RESET;
                ch_q_offset <= OFFSET_RESET;
            end
            bias_enable <= ~dc_coupled;
        end
    end

    // ========================================
    // calibration request qualification and run timer
    localparam int CW = $clog2(RUN_CYC + CAL_LOW_CYC + CAL_HIGH_CYC + 1);
    logic           cal_req;
    acs_cal_state_t cal_st_r;
    logic [CW-1:0]  cal_cnt_r;
    assign cal_req = pin_r[4] | (ext_mode & cfg_r[CFG_CAL_BIT]);

    // a glitch-free low then high of the minimum widths is needed; an upset
    // shorter than that never starts a run
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cal_st_r  <= CS_ARM;
            cal_cnt_r <= '0;
        end else begin
            case (cal_st_r)
                CS_ARM: begin
                    cal_cnt_r <= '0;
                    if (!cal_req) begin
                        cal_st_r <= CS_LOW;
                    end
                end
                CS_LOW: begin
                    if (cal_req) begin
                        cal_st_r  <= (cal_cnt_r >= CW'(CAL_LOW_CYC)) ? CS_HIGH : CS_ARM;
                        cal_cnt_r <= '0;
                    end else if (cal_cnt_r < CW'(CAL_LOW_CYC)) begin
                        cal_cnt_r <= cal_cnt_r + CW'(1);
                    end
                end
                CS_HIGH: begin
                    if (!cal_req) begin
                        cal_st_r  <= CS_LOW;
                        cal_cnt_r <= '0;
                    end else if (cal_cnt_r >= CW'(CAL_HIGH_CYC - 1)) begin
                        cal_st_r  <= CS_RUN;
                        cal_cnt_r <= '0;
                    end else begin
                        cal_cnt_r <= cal_cnt_r + CW'(1);
                    end
                end
                CS_RUN: begin
                    // requests during a run are ignored
                    if (cal_cnt_r >= CW'(RUN_CYC - 1)) begin
                        cal_st_r  <= CS_ARM;
                        cal_cnt_r <= '0;
                    end else begin
                        cal_cnt_r <= cal_cnt_r + CW'(1);
                    end
                end
                default: begin
                    cal_st_r  <= CS_ARM;
                    cal_cnt_r <= '0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            calibration_running <= 1'b0;
        end else begin
            calibration_running <= (cal_st_r == CS_RUN);
        end
    end
endmodule

// ### rtl/acs_pkg.sv
// acs_pkg: constants shared by the converter control block.
// assumes a 100 MHz mclk and a 16-bit serial register map.
package acs_pkg;
    // ========================================
    // register map (word index = printed offset)
    localparam logic [3:0]  ADDR_CONFIG      = 4'h0;
    localparam logic [3:0]  ADDR_I_OFFSET    = 4'h2;
    localparam logic [3:0]  ADDR_I_RANGE     = 4'h3;
    localparam logic [3:0]  ADDR_Q_OFFSET    = 4'hA;
    localparam logic [3:0]  ADDR_Q_RANGE     = 4'hB;
    // ========================================
    // configuration fields
    localparam int          CFG_CAL_BIT      = 15;
    localparam int          CFG_DES_BIT      = 7;
    localparam int          CFG_QSEL_BIT     = 6;
    // ========================================
    // reset values and range codes
    localparam logic [15:0] CFG_RESET        = 16'h0000;
    localparam logic [15:0] OFFSET_RESET     = 16'h0000;
    localparam logic [15:0] RANGE_MIN        = 16'h0000;
    localparam logic [15:0] RANGE_MID        = 16'h8000;
    localparam logic [15:0] RANGE_RESET      = 16'h8000;
    // ========================================
    // timing
    localparam int          CLK_MHZ          = 100;
    localparam int          CAL_LOW_NS       = 80;
    localparam int          CAL_HIGH_NS      = 80;
    localparam int          CAL_LOW_CYC      = (CAL_LOW_NS * CLK_MHZ + 999) / 1000;
    localparam int          CAL_HIGH_CYC     = (CAL_HIGH_NS * CLK_MHZ + 999) / 1000;
    localparam int          CAL_RUN_CYC      = 1000;
    // ========================================
    // calibration sequencer states, gray along the path
    typedef enum logic [1:0] {
        CS_ARM  = 2'b00,
        CS_LOW  = 2'b01,
        CS_HIGH = 2'b11,
        CS_RUN  = 2'b10
    } acs_cal_state_t;
endpackage

// ### sim/acs_ctrl_assertions.sv
// acs_chk: port checks for the converter control block.
// assumes one mclk domain, async active-high rst; bound below.
`timescale 1ns/1ps
module acs_chk
    import acs_pkg::*;
#(
    parameter int RUN_CYC = CAL_RUN_CYC
) (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        coupling_mode_select,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [3:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic        port_enabled,
    input wire logic        interleave_active,
    input wire logic        ch_i_sel_quad,
    input wire logic        ch_q_sel_quad,
    input wire logic [15:0] ch_i_range,
    input wire logic [15:0] ch_q_range,
    input wire logic        bias_enable,
    input wire logic        calibration_running
);
    int run_r;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // ========================================
    // run length counter; cleared while idle
    always_ff @(posedge mclk or posedge rst) begin
        if (rst)
            run_r <= 0;
        else
            run_r <= calibration_running ? run_r + 1 : 0;
    end
    AST_RUN_LEN: assert property ($fell(calibration_running) |-> run_r == RUN_CYC)
        else $error("run length wrong");
    AST_RUN_GAP: assert property ($fell(calibration_running) |-> !calibration_running [*8])
        else $error("run restarted without new request");
    AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data outside read cycle");
    // register takes the word on the write edge, the output one edge later
    AST_RANGE_WR: assert property (reg_wr && reg_addr == ADDR_I_RANGE ##1 port_enabled
        ##1 port_enabled |-> ch_i_range == $past(reg_wdata, 2)) else $error("range write lost");
    AST_BASIC_RANGE: assert property (!port_enabled && !$past(port_enabled)
        |-> ch_i_range == ch_q_range && (ch_i_range == RANGE_MID || ch_i_range == RANGE_MIN))
        else $error("basic range differs");
    AST_INDEP: assert property (!interleave_active |-> !ch_i_sel_quad && ch_q_sel_quad)
        else $error("independent input wrong");
    AST_BASIC_DES: assert property (interleave_active && !port_enabled
        && !$past(port_enabled) |-> !ch_i_sel_quad && !ch_q_sel_quad)
        else $error("basic interleave not in-phase");
    AST_BIAS: assert property (coupling_mode_select [*8] |-> !bias_enable)
        else $error("bias on while dc coupled");
endmodule
bind acs_ctrl acs_chk #(.RUN_CYC(RUN_CYC)) u_chk (.mclk(mclk), .rst(rst),
    .coupling_mode_select(coupling_mode_select), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .port_enabled(port_enabled), .interleave_active(interleave_active),
    .ch_i_sel_quad(ch_i_sel_quad), .ch_q_sel_quad(ch_q_sel_quad), .ch_i_range(ch_i_range),
    .ch_q_range(ch_q_range), .bias_enable(bias_enable),
    .calibration_running(calibration_running));

// ### sim/acs_host.sv
// acs_host: host model for the request pin and register strobes.
// assumes the bench clock; outputs change on falling edges only.
`timescale 1ns/1ps
module acs_host (
    input wire logic   mclk,
    output logic       cal_request_pin,
    output logic       reg_wr,
    output logic       reg_rd,
    output logic [3:0] reg_addr,
    output logic [15:0] reg_wdata
);
    initial begin
        cal_request_pin = 1'b1;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    end
    // one-cycle strobe; released bus scrambled so stale data never passes
    task automatic acc(input logic wr, input logic [3:0] a, input logic [15:0] d);
        @(negedge mclk);
        {reg_wr, reg_rd, reg_addr, reg_wdata} = {wr, !wr, a, d};
        @(negedge mclk);
        {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b00, ~a, ~d};
    endtask
    // low phase then high phase, each past the 8-cycle minimum
    task automatic cal(input logic by_bit, input logic [15:0] cfg);
        @(negedge mclk);
        cal_request_pin = 1'b0;
        if (by_bit)
            acc(1'b1, 4'h0, cfg & 16'h7fff);
        repeat (10) @(negedge mclk);
        if (by_bit)
            acc(1'b1, 4'h0, cfg | 16'h8000);
        else
            cal_request_pin = 1'b1;
        repeat (10) @(negedge mclk);
        cal_request_pin = 1'b1;
        if (by_bit)
            acc(1'b1, 4'h0, cfg & 16'h7fff);
    endtask
endmodule

// ### sim/test_adc_calibration_and_input_select.sv
// test bench for acs_ctrl with host model and bound checker.
// assumes acs_pkg and acs_host; pins driven on falling edges.
`timescale 1ns/1ps
module test_adc_calibration_and_input_select;
    import acs_pkg::*;
    localparam int RUN = 20;
    localparam logic [3:0] AT [4] = '{ADDR_I_OFFSET, ADDR_I_RANGE, ADDR_Q_OFFSET, ADDR_Q_RANGE};
    logic mclk, rst, ext_n, il_pin, rng_pin, dc_pin, pe, ila, iq, qq, dual, bias, run;
    logic cal, wr, rd;
    logic [3:0] addr;
    logic [15:0] wd, rdata, ir, qr, io, qo, cfg;
    logic [15:0] w [4];
    int fails, n_tests, hi, st;
    acs_ctrl #(.RUN_CYC(RUN)) dut (.mclk(mclk), .rst(rst), .extended_control_pin(ext_n),
        .interleave_pin(il_pin), .range_select_pin(rng_pin), .coupling_mode_select(dc_pin),
        .cal_request_pin(cal), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wd),
        .reg_rdata(rdata), .port_enabled(pe), .interleave_active(ila), .ch_i_sel_quad(iq),
        .ch_q_sel_quad(qq), .ch_q_dual_edge(dual), .ch_i_range(ir), .ch_q_range(qr),
        .ch_i_offset(io), .ch_q_offset(qo), .bias_enable(bias), .calibration_running(run));
    acs_host host (.mclk(mclk), .cal_request_pin(cal), .reg_wr(wr), .reg_rd(rd),
        .reg_addr(addr), .reg_wdata(wd));
    // ========================================
    // expected {interleave, i quad, q quad}
    function automatic logic [2:0] exp_sel(input logic ext, input logic p, input logic [15:0] c);
        if (!(ext ? c[CFG_DES_BIT] : p))
            return 3'b001;
        return {1'b1, {2{ext & c[CFG_QSEL_BIT]}}};
    endfunction
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic settle();
        repeat (8) @(negedge mclk);
    endtask
    // run cycles and run starts over a fixed window
    task automatic watch();
        logic prev;
        {hi, st, prev} = '0;
        repeat (120) begin
            @(negedge mclk);
            hi += run;
            st += run & !prev;
            prev = run;
        end
    endtask
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // watchdog, well past the expected run time
    initial begin
        #100us;
        fails++;
        finish_test();
    end
    initial begin
        {fails, n_tests} = '0;
        {rst, ext_n, il_pin, rng_pin, dc_pin} = 5'b11010;
        void'($urandom(48166));
        repeat (3) @(negedge mclk);
        rst = 1'b0;
        for (int k = 0; k < 4; k++) begin
            {rng_pin, il_pin} = k[1:0];
            dc_pin = k[0] ^ k[1];
            settle();
            chk({ila, iq, qq}, exp_sel(1'b0, il_pin, CFG_RESET));
            chk({ir, qr}, {2{k[1] ? RANGE_MID : RANGE_MIN}});
            chk(bias, !dc_pin);
        end
        // second request lands while running and must be ignored
        fork
            begin
                host.cal(1'b0, 16'h0000);
                host.cal(1'b0, 16'h0000);
            end
            watch();
        join
        chk({hi[15:0], st[15:0]}, {16'(RUN), 16'h0001});
        ext_n = 1'b0;
        settle();
        chk({pe, ila, iq, qq}, {1'b1, exp_sel(1'b1, il_pin, CFG_RESET)});
        for (int k = 0; k < 4; k++) begin
            w[k] = 16'($urandom);
            host.acc(1'b1, AT[k], w[k]);
        end
        @(negedge mclk); // last write reaches the outputs one edge late
        chk({io, ir, qo, qr}, {w[0], w[1], w[2], w[3]});
        for (int k = 0; k < 5; k++) begin
            host.acc(1'b0, k < 4 ? AT[k] : 4'h5, 16'h0000);
            chk(rdata, k < 4 ? w[k] : 16'h0000);
        end
        for (int k = 0; k < 4; k++) begin
            cfg = {8'h00, k[1:0], 6'h00};
            il_pin = 1'($urandom);
            host.acc(1'b1, ADDR_CONFIG, cfg);
            settle();
            chk({ila, iq, qq, dual}, {exp_sel(1'b1, il_pin, cfg), cfg[7]});
        end
        fork
            host.cal(1'b1, 16'h0000);
            watch();
        join
        chk({hi[15:0], st[15:0]}, {16'(RUN), 16'h0001});
        ext_n = 1'b1;
        settle();
        chk({pe, io, qo}, 33'h0_0000_0000);
        chk({ir, qr}, {2{RANGE_MID}});
        host.acc(1'b0, ADDR_I_RANGE, 16'h0000);
        chk(rdata, 16'h0000);
        finish_test();
    end
endmodule
